// *** src/temp_peak_regs.v ***
// What this block does
// - Local fraction at 01h: bits 7..4 weigh 0.5 to 0.0625, low nibble zero.
// - Remote results as integer/fraction pairs at 02h/03h, 04h/05h, 06h/07h.
// - Result and peak registers are read-only, volatile, reset to 00h.
// - Peak holds largest selected channel temperature minus its reference.
// - Peak integer at 10h, fraction at 11h in bits 7..4, low nibble zero.
// - Select register 12h: bit 0 local, bits 1..3 remote; one includes.
// - Select register resets to 0Fh, all four channels taking part.
// - Select bits 7..4 are reserved, reset to zero, no effect.
// - Local integer result at 00h, read-only, sign plus weights 64..1.
// - Writable per-channel reference pairs at 40h..47h, reset to zero.
`timescale 1ns/1ps
`default_nettype none
`include "temp_peak_map.vh"

module temp_peak_regs #(
  parameter CH_NUM = 4,
  parameter TW = 12
) (
  input wire clk_sys_i,
  input wire rst_i,
  input wire ce_i,
  // Register port
  input wire rd_en_i,
  input wire wr_en_i,
  input wire [6:0] reg_addr_i,
  input wire [7:0] wr_data_i,
  output reg [7:0] rd_data_o,
  output reg rd_valid_o,
  // Converter side
  input wire res_we_i,
  input wire [1:0] res_ch_i,
  input wire [7:0] res_int_i,
  input wire [3:0] res_frac_i,
  input wire cycle_done_i,
  output reg peak_busy_o
);

  localparam S_IDLE = 5'b00001;
  localparam S_MSB = 5'b00010;
  localparam S_LSB = 5'b00100;
  localparam S_CMP = 5'b01000;
  localparam S_DONE = 5'b10000;

  localparam [TW:0] SAT_POS = 13'h07ff;
  localparam [TW:0] SAT_NEG = 13'h1800;

  // One signed value per channel: integer byte over fraction nibble
  reg [TW-1:0] result_reg [0:CH_NUM-1];
  reg [7:0] peak_int_reg;
  reg [3:0] peak_frac_reg;
  reg [7:0] select_reg;

  reg [4:0] state_reg;
  reg [4:0] state_next;
  reg [1:0] ch_reg;
  reg [7:0] ref_msb_reg;
  reg [TW:0] best_reg;
  reg found_reg;

  reg rd_stage_reg;
  reg rd_mem_sel_reg;
  reg [7:0] rd_pre_reg;

  wire [7:0] ref_rd_a;
  wire [7:0] ref_rd_b;
  wire [2:0] ref_addr_b;
  wire ref_wr;
  wire addr_is_ref;
  wire addr_is_res;

  reg [7:0] rd_mux;
  reg [TW:0] diff;
  reg ch_selected;
  integer i;

  function [TW:0] sext;
    input [TW-1:0] v;
    begin
      sext = {v[TW-1], v};
    end
  endfunction

  function signed_gt;
    input [TW:0] a;
    input [TW:0] b;
    begin
      signed_gt = $signed(a) > $signed(b);
    end
  endfunction

  function [TW-1:0] sat;
    input [TW:0] v;
    begin
      if (signed_gt(v, SAT_POS)) begin
        sat = SAT_POS[TW-1:0];
      end else if (signed_gt(SAT_NEG, v)) begin
        sat = SAT_NEG[TW-1:0];
      end else begin
        sat = v[TW-1:0];
      end
    end
  endfunction

  function [7:0] frac_byte;
    input [3:0] f;
    begin
      frac_byte = {f, 4'h0};
    end
  endfunction

  assign addr_is_res = reg_addr_i[`RES_BLOCK_MSB:`RES_BLOCK_LSB] == `RES_BLOCK_TAG;
  assign addr_is_ref = reg_addr_i[`RES_BLOCK_MSB:`RES_BLOCK_LSB] == `REF_BLOCK_TAG;
  assign ref_wr = wr_en_i && addr_is_ref;
  assign ref_addr_b = {ch_reg, state_reg == S_LSB};

  ref_temp_mem #(
    .AW(3),
    .DW(8)
  ) u_ref_mem (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .wr_en_i(ref_wr),
    .wr_addr_i(reg_addr_i[2:0]),
    .wr_data_i(wr_data_i),
    .rd_addr_a_i(reg_addr_i[2:0]),
    .rd_data_a_o(ref_rd_a),
    .rd_addr_b_i(ref_addr_b),
    .rd_data_b_o(ref_rd_b)
  );

  // Read mux for everything held in this module
  always @* begin
    rd_mux = `UNMAPPED_READ;
    if (addr_is_res) begin
      if (reg_addr_i[0]) begin
        rd_mux = frac_byte(result_reg[reg_addr_i[2:1]][3:0]);
      end else begin
        rd_mux = result_reg[reg_addr_i[2:1]][TW-1:4];
      end
    end else begin
      case (reg_addr_i)
        `ADDR_PEAK_INT: begin
          rd_mux = peak_int_reg;
        end
        `ADDR_PEAK_FRAC: begin
          rd_mux = frac_byte(peak_frac_reg);
        end
        `ADDR_PEAK_SELECT: begin
          rd_mux = select_reg;
        end
        default: begin
          rd_mux = `UNMAPPED_READ;
        end
      endcase
    end
  end

  // Two-cycle read so reference bytes come from the memory's register
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      rd_stage_reg <= 1'b0;
      rd_mem_sel_reg <= 1'b0;
      rd_pre_reg <= `UNMAPPED_READ;
      rd_data_o <= `UNMAPPED_READ;
      rd_valid_o <= 1'b0;
    end else if (ce_i) begin
      rd_stage_reg <= rd_en_i;
      if (rd_en_i) begin
        rd_mem_sel_reg <= addr_is_ref;
        rd_pre_reg <= rd_mux;
      end
      rd_valid_o <= rd_stage_reg;
      if (rd_stage_reg) begin
        rd_data_o <= rd_mem_sel_reg ? ref_rd_a : rd_pre_reg;
      end
    end
  end

  // Select register and channel results
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      select_reg <= `PEAK_SELECT_RESET;
      for (i = 0; i < CH_NUM; i = i + 1) begin
        result_reg[i] <= {`RESULT_RESET, 4'h0};
      end
    end else if (ce_i) begin
      // Reserved upper bits are stored but never steer anything
      if (wr_en_i && reg_addr_i == `ADDR_PEAK_SELECT) begin
        select_reg <= wr_data_i;
      end
      // Bus writes never reach these; only the converter loads them
      if (res_we_i) begin
        result_reg[res_ch_i] <= {res_int_i, res_frac_i};
      end
    end
  end

  always @* begin
    ch_selected = select_reg[ch_reg];
    diff = sext(result_reg[ch_reg]) - sext({ref_msb_reg, ref_rd_b[7:4]});
  end

  always @* begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE: begin
        if (cycle_done_i) begin
          state_next = S_MSB;
        end
      end
      S_MSB: begin
        state_next = S_LSB;
      end
      S_LSB: begin
        state_next = S_CMP;
      end
      S_CMP: begin
        state_next = (ch_reg == CH_NUM - 1) ? S_DONE : S_MSB;
      end
      S_DONE: begin
        state_next = S_IDLE;
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
  end

  // Peak search: one channel per three cycles, commit at the end
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_reg <= S_IDLE;
      ch_reg <= 2'd0;
      ref_msb_reg <= `REF_RESET;
      best_reg <= {(TW+1){1'b0}};
      found_reg <= 1'b0;
      peak_int_reg <= `PEAK_RESET;
      peak_frac_reg <= 4'h0;
      peak_busy_o <= 1'b0;
    end else if (ce_i) begin
      state_reg <= state_next;
      peak_busy_o <= state_next != S_IDLE;
      case (state_reg)
        S_IDLE: begin
          ch_reg <= 2'd0;
          found_reg <= 1'b0;
        end
        S_LSB: begin
          ref_msb_reg <= ref_rd_b;
        end
        S_CMP: begin
          if (ch_selected && (!found_reg || signed_gt(diff, best_reg))) begin
            best_reg <= diff;
            found_reg <= 1'b1;
          end
          ch_reg <= ch_reg + 2'd1;
        end
        S_DONE: begin
          if (found_reg) begin
            {peak_int_reg, peak_frac_reg} <= sat(best_reg);
          end
        end
        default: begin
          ch_reg <= ch_reg;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// *** src/temp_peak_map.vh ***
`ifndef TEMP_PEAK_MAP_VH
`define TEMP_PEAK_MAP_VH

// Register addresses, 7-bit register pointer
`define ADDR_LOCAL_INT 7'h00
`define ADDR_LOCAL_FRAC 7'h01
`define ADDR_REMOTE_ONE_INT 7'h02
`define ADDR_REMOTE_ONE_FRAC 7'h03
`define ADDR_REMOTE_TWO_INT 7'h04
`define ADDR_REMOTE_TWO_FRAC 7'h05
`define ADDR_REMOTE_THREE_INT 7'h06
`define ADDR_REMOTE_THREE_FRAC 7'h07
`define ADDR_PEAK_INT 7'h10
`define ADDR_PEAK_FRAC 7'h11
`define ADDR_PEAK_SELECT 7'h12
`define ADDR_REF_FIRST 7'h40
`define ADDR_REF_LAST 7'h47

// Result block: addresses 00h..07h share this upper pointer field
`define RES_BLOCK_TAG 4'h0
`define RES_BLOCK_MSB 6
`define RES_BLOCK_LSB 3
// Reference block: addresses 40h..47h share this upper pointer field
`define REF_BLOCK_TAG 4'h8

// Field positions
`define FRAC_FIELD_MSB 7
`define FRAC_FIELD_LSB 4
`define SEL_LOCAL_BIT 0
`define SEL_REMOTE_ONE_BIT 1
`define SEL_REMOTE_TWO_BIT 2
`define SEL_REMOTE_THREE_BIT 3
`define SEL_USED_MSB 3

// Reset values
`define RESULT_RESET 8'h00
`define PEAK_RESET 8'h00
`define PEAK_SELECT_RESET 8'h0f
`define REF_RESET 8'h00
`define UNMAPPED_READ 8'h00

`endif

// *** src/ref_temp_mem.v ***
`timescale 1ns/1ps
`default_nettype none
`include "temp_peak_map.vh"

// Small byte store with one write port and two registered read ports
module ref_temp_mem #(
  parameter AW = 3,
  parameter DW = 8
) (
  input wire clk_sys_i,
  input wire rst_i,
  input wire ce_i,
  input wire wr_en_i,
  input wire [AW-1:0] wr_addr_i,
  input wire [DW-1:0] wr_data_i,
  input wire [AW-1:0] rd_addr_a_i,
  output reg [DW-1:0] rd_data_a_o,
  input wire [AW-1:0] rd_addr_b_i,
  output reg [DW-1:0] rd_data_b_o
);

  localparam DEPTH = 1 << AW;

  reg [DW-1:0] mem_reg [0:DEPTH-1];
  integer i;

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem_reg[i] <= `REF_RESET;
      end
      rd_data_a_o <= `REF_RESET;
      rd_data_b_o <= `REF_RESET;
    end else if (ce_i) begin
      if (wr_en_i) begin
        mem_reg[wr_addr_i] <= wr_data_i;
      end
      rd_data_a_o <= mem_reg[rd_addr_a_i];
      rd_data_b_o <= mem_reg[rd_addr_b_i];
    end
  end

endmodule

`default_nettype wire

// *** dv/temp_peak_regs_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module temp_peak_regs_props(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic rd_en_i,
  input wire logic wr_en_i,
  input wire logic [6:0] reg_addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic [7:0] rd_data_o,
  input wire logic rd_valid_o,
  input wire logic res_we_i,
  input wire logic [1:0] res_ch_i,
  input wire logic [7:0] res_int_i,
  input wire logic [3:0] res_frac_i,
  input wire logic cycle_done_i,
  input wire logic peak_busy_o
);
  default clocking @(posedge clk_sys_i);
  endclocking
  // A low clock enable freezes the block, so no cycle count holds across it
  default disable iff (rst_i || !ce_i);
  sequence res_load_rd;
    res_we_i ##1 rd_en_i && !res_we_i && reg_addr_i[6:3] == 4'h0
      && reg_addr_i[2:1] == $past(res_ch_i);
  endsequence
  sequence busy_run;
    peak_busy_o [*8] ##5 peak_busy_o ##1 !peak_busy_o;
  endsequence
  read_lat_a: assert property (rd_en_i |-> ##2 rd_valid_o)
    else $error("read not answered in two cycles");
  valid_cause_a: assert property (rd_valid_o |-> $past(rd_en_i, 2))
    else $error("read valid without request");
  hold_data_a: assert property (!rd_valid_o && !$past(rst_i) |-> $stable(rd_data_o))
    else $error("read data changed without read");
  frac_nib_a: assert property (rd_valid_o && $past(reg_addr_i[0], 2)
    && ($past(reg_addr_i, 2) < 7'h08 || $past(reg_addr_i, 2) == 7'h11)
    |-> rd_data_o[3:0] == 4'h0) else $error("fraction low nibble not zero");
  unmapped_a: assert property (rd_valid_o && $past(reg_addr_i, 2) inside
    {[7'h08:7'h0f], [7'h13:7'h3f], [7'h48:7'h7f]} |-> rd_data_o == 8'h00)
    else $error("unmapped read not zero");
  res_rd_a: assert property (res_load_rd |-> ##2 rd_data_o ==
    ($past(reg_addr_i[0], 2) ? {$past(res_frac_i, 3), 4'h0} : $past(res_int_i, 3)))
    else $error("result readback wrong");
  busy_len_a: assert property (cycle_done_i && !peak_busy_o |=> busy_run)
    else $error("search length wrong");
  busy_cause_a: assert property ($rose(peak_busy_o) |-> $past(cycle_done_i))
    else $error("search started without cycle end");
endmodule
bind temp_peak_regs temp_peak_regs_props u_props(.clk_sys_i(clk_sys_i), .rst_i(rst_i),
  .ce_i(ce_i), .rd_en_i(rd_en_i), .wr_en_i(wr_en_i), .reg_addr_i(reg_addr_i),
  .wr_data_i(wr_data_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
  .res_we_i(res_we_i), .res_ch_i(res_ch_i), .res_int_i(res_int_i),
  .res_frac_i(res_frac_i), .cycle_done_i(cycle_done_i), .peak_busy_o(peak_busy_o));
`default_nettype wire

// *** dv/reg_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module reg_host(
  input wire logic clk_sys_i,
  input wire logic [7:0] rd_data_i,
  input wire logic rd_valid_i,
  output logic rd_en_o,
  output logic wr_en_o,
  output logic [6:0] addr_o,
  output logic [7:0] data_o
);
  initial begin
    rd_en_o = 0;
    wr_en_o = 0;
    addr_o = 0;
    data_o = 0;
  end
  // Entered at a falling edge; released lines are scrambled
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    wr_en_o = 1;
    addr_o = a;
    data_o = d;
    @(negedge clk_sys_i);
    wr_en_o = 0;
    addr_o = ~a;
    data_o = ~d;
    @(negedge clk_sys_i);
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    rd_en_o = 1;
    addr_o = a;
    @(negedge clk_sys_i);
    rd_en_o = 0;
    addr_o = ~a;
    for (int n = 0; n < 4 && rd_valid_i !== 1'b1; n++) @(negedge clk_sys_i);
    // A read that is never answered hands back unknowns so the compare trips
    d = rd_valid_i === 1'b1 ? rd_data_i : 8'hxx;
  endtask
endmodule
`default_nettype wire

// *** dv/temp_result_and_highest_select_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module temp_result_and_highest_select_bench;
  logic clk_sys_i = 0, rst_i = 1, res_we_i = 0, cycle_done_i = 0, ce_i = 1;
  logic rd_en_i, wr_en_i, rd_valid_o, peak_busy_o;
  logic [1:0] res_ch_i = 0;
  logic [3:0] res_frac_i = 0;
  logic [6:0] reg_addr_i;
  logic [7:0] res_int_i = 0, wr_data_i, rd_data_o, d, exp_byte;
  int miscompares = 0, check_count = 0;
  logic [6:0] ra [13] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h06, 7'h07,
    7'h10, 7'h11, 7'h47, 7'h20, 7'h12};
  // Select, four results as int.frac, expected peak pair
  // Last row drives remote one below its reference into negative saturation
  logic [71:0] rows [7] = '{72'h0f_1901_a8ff_0055_1a80, 72'h05_1907_f0fe_87ff_1900,
    72'hf8_7f07_f07f_0e21_e210, 72'h00_7f07_f07f_07f0_e210,
    72'h02_0008_007f_07f0_8000, 72'h0f_0a01_1080_0800_0b80, 72'h02_0a08_0080_0800_8000};
  initial forever #2 clk_sys_i = ~clk_sys_i;
  temp_peak_regs u_dut(.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i),
    .rd_en_i(rd_en_i), .wr_en_i(wr_en_i), .reg_addr_i(reg_addr_i),
    .wr_data_i(wr_data_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
    .res_we_i(res_we_i), .res_ch_i(res_ch_i), .res_int_i(res_int_i),
    .res_frac_i(res_frac_i), .cycle_done_i(cycle_done_i), .peak_busy_o(peak_busy_o));
  reg_host u_host(.clk_sys_i(clk_sys_i), .rd_data_i(rd_data_o), .rd_valid_i(rd_valid_o),
    .rd_en_o(rd_en_i), .wr_en_o(wr_en_i), .addr_o(reg_addr_i), .data_o(wr_data_i));
  task chk8(input logic [6:0] a, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("Error reg %h expected %h seen %h", a, e, g);
    end
  endtask
  task chk1(input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("Error peak_busy_o expected %b seen %b", e, g);
    end
  endtask
  task rc(input logic [6:0] a, input logic [7:0] e);
    u_host.rd(a, d);
    chk8(a, e, d);
  endtask
  task report_and_stop;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #100000;
    miscompares++;
    report_and_stop;
  end
  initial begin
    repeat (16) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    rst_i = 0;
    foreach (ra[i]) rc(ra[i], i == 12 ? 8'h0f : 8'h00);
    u_host.wr(7'h10, 8'h55);
    u_host.wr(7'h01, 8'h5a);
    rc(7'h10, 8'h00);
    rc(7'h01, 8'h00);
    foreach (rows[r]) begin
      for (int c = 0; c < 4; c++) begin
        res_we_i = 1;
        res_ch_i = 2'(c);
        {res_int_i, res_frac_i} = rows[r][63-12*c -: 12];
        @(negedge clk_sys_i);
      end
      res_we_i = 0;
      u_host.rd({6'h03, r[0]}, d);
      for (int c = 0; c < 8; c++) begin
        exp_byte = c[0] ? {rows[r][55-12*(c/2) -: 4], 4'h0} : rows[r][63-12*(c/2) -: 8];
        rc(7'(c), exp_byte);
      end
      if (r == 5) begin
        u_host.wr(7'h42, 8'h05);
        u_host.wr(7'h43, 8'h80);
        rc(7'h42, 8'h05);
        rc(7'h43, 8'h80);
      end
      u_host.wr(7'h12, rows[r][71:64]);
      rc(7'h12, rows[r][71:64]);
      cycle_done_i = 1;
      @(negedge clk_sys_i);
      cycle_done_i = 0;
      for (int n = 0; n < 40 && peak_busy_o !== 1'b0; n++) @(negedge clk_sys_i);
      chk1(1'b0, peak_busy_o);
      rc(7'h10, rows[r][15:8]);
      rc(7'h11, rows[r][7:0]);
    end
    // Search and a select write while the clock enable is low must freeze
    u_host.wr(7'h12, 8'h01);
    cycle_done_i = 1;
    @(negedge clk_sys_i);
    cycle_done_i = 0;
    ce_i = 0;
    u_host.wr(7'h12, 8'h0f);
    repeat (20) @(negedge clk_sys_i);
    chk1(1'b1, peak_busy_o);
    ce_i = 1;
    for (int n = 0; n < 40 && peak_busy_o !== 1'b0; n++) @(negedge clk_sys_i);
    chk1(1'b0, peak_busy_o);
    rc(7'h10, 8'h0a);
    rc(7'h11, 8'h00);
    rc(7'h12, 8'h01);
    rst_i = 1;
    repeat (16) @(negedge clk_sys_i);
    rst_i = 0;
    rc(7'h12, 8'h0f);
    rc(7'h10, 8'h00);
    rc(7'h02, 8'h00);
    rc(7'h42, 8'h00);
    report_and_stop;
  end
endmodule
`default_nettype wire
